// File: design/eisf_top.sv
`timescale 1ns/100ps
// Contract
// RULE1 - Only channels 5,4,1,0 at matching bits
// RULE2 - Sense 0: low level requests interrupt
// RULE3 - Sense 1: falling edge requests interrupt
// RULE4 - Enable 0 blocks channel request
// RULE5 - Enable 1 forwards pending request
// RULE6 - Level mode sets flag while low
// RULE7 - Edge mode sets flag on fall
// RULE8 - Clear needs read of 1, write 0
// RULE9 - Level flag clears: pin high, handled
// RULE10 - Edge flag clears when exception handled
// RULE11 - Flag writes only clear, never set
// RULE12 - Request is flag and enable; reset zeros
module eisf_top (
    input  wire logic                          sys_clk,
    input  wire logic                          srst,
    input  wire eisf_pkg::eisf_bus_s           bus_req,           // Register bus request
    output logic      [eisf_pkg::DATA_W-1:0]   rd_data,           // Read answer, next cycle
    input  wire logic [eisf_pkg::NCHAN-1:0]    ext_request_pin_n, // Active-low request pins
    input  wire logic [eisf_pkg::NCHAN-1:0]    exc_done,          // Exception handling pulses
    output logic      [eisf_pkg::NCHAN-1:0]    irq_req            // Requests to the processor
);
    import eisf_pkg::*;

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [DATA_W-1:0] sense_q,  sense_d;   // irq_sense_select
    logic [DATA_W-1:0] enable_q, enable_d;  // irq_enable_mask
    logic [NCHAN-1:0]  flags_q;             // irq_pending_flags
    logic [NCHAN-1:0]  flags_d;             // Next flags
    logic [NCHAN-1:0]  irq_q,    irq_d;     // Forwarded requests
    eisf_reg_e         sel;                 // Decoded address
    logic              flag_rd;             // Flag register read
    logic              flag_wr;             // Flag register write

    // ************************************************************
    // Address decode
    // ************************************************************
    always_comb begin
        // Whole byte compared: no alias can reach a flag
        // through a stray write
        // Unmapped addresses decode to none
        unique case (bus_req.addr)
            OFF_SENSE:  sel = REG_SENSE;
            OFF_ENABLE: sel = REG_ENABLE;
            OFF_FLAGS:  sel = REG_FLAGS;
            default:    sel = REG_NONE;
        endcase
        // Flag register strobes, shared by all channels
        flag_rd = bus_req.rd & (sel == REG_FLAGS);
        flag_wr = bus_req.wr & (sel == REG_FLAGS);
    end

    // ************************************************************
    // Control registers
    // ************************************************************
    // All eight bits are kept, the spare ones read back as written
    // Four spare flops per register keep read-back plain; they feed
    // no channel, so writing them does nothing
    always_comb begin
        sense_d  = sense_q;
        enable_d = enable_q;
        // A write replaces the whole byte
        if (bus_req.wr && sel == REG_SENSE) begin
            sense_d = bus_req.wdata;
        end
        if (bus_req.wr && sel == REG_ENABLE) begin
            enable_d = bus_req.wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sense_q  <= RST_SENSE;                                  // see RULE12
            enable_q <= RST_ENABLE;                                 // see RULE12
        end else begin
            sense_q  <= sense_d;
            enable_q <= enable_d;
        end
    end

    // ************************************************************
    // Channel instances
    // ************************************************************
    // Only populated bit positions get sensing logic
    // Each live channel keeps its pin history, arm bit
    // and flag; the flag strobes reach all of them
    // Absent bits cost no channel flops
    for (genvar i = 0; i < NCHAN; i++) begin : g_chan
        if (CHAN_MASK[i]) begin : g_live                            // see RULE1
            eisf_chan u_chan (
                .sys_clk           (sys_clk),
                .srst              (srst),
                .ext_request_pin_n (ext_request_pin_n[i]),
                .chan_sense_select (sense_q[i]),
                .exc_done          (exc_done[i]),
                .flag_rd           (flag_rd),
                .flag_wr           (flag_wr),
                .flag_wbit         (bus_req.wdata[i]),
                .chan_pending_flag (flags_q[i]),
                .flag_d            (flags_d[i])
            );
        end else begin : g_none
            // Absent channel: flag stays at its reset value
            // Constants only, nothing to clock
            assign flags_q[i] = RST_FLAGS[i];
            assign flags_d[i] = RST_FLAGS[i];
        end
    end

    // ************************************************************
    // Request outputs
    // ************************************************************
    // Built from next values so the output lines up with the flag flop
    // irq_req stays a plain flop yet never lags
    // the flag or the enable by a cycle
    // Absent bits are masked off
    always_comb begin
        irq_d = flags_d & enable_d & CHAN_MASK;                     // see RULE4 see RULE5 see RULE12
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            // Requests drop with the flags
            irq_q <= '0;
        end else begin
            irq_q <= irq_d;
        end
    end

    // Straight from the flop
    assign irq_req = irq_q;

    // ************************************************************
    // Read port
    // ************************************************************
    // Idle cycles read zero, so a sample
    // taken a cycle late never passes
    // for register data
    eisf_rdport u_rd (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .rd       (bus_req.rd),
        .rd_sel   (sel),
        .sense_q  (sense_q),
        .enable_q (enable_q),
        .flags_q  (flags_q),
        .rd_data  (rd_data)
    );

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    // Checks rest while reset is held;
    // most name the cycle after the cause,
    // when the flag flop has loaded

    // Absent channels never show a flag or request
    AST_ABSENT_ZERO: assert property (((flags_q | irq_req) & ~CHAN_MASK) == '0) // see RULE1
        else $error("absent channel shows flag or request");

    // Request mirrors flag and enable
    AST_IRQ_IS_FLAG_AND_EN: assert property (irq_req == (flags_q & enable_q & CHAN_MASK)) // see RULE12
        else $error("request differs from flag and enable");

    // Control registers come out of reset at zero
    AST_RESET_ZERO: assert property ($past(srst) |-> sense_q == '0 && enable_q == '0 && flags_q == '0) // see RULE12
        else $error("registers not zero after reset");

    // Enable register read answers one cycle later
    AST_READ_ENABLE: assert property (bus_req.rd && sel == REG_ENABLE |=> rd_data == $past(enable_q))
        else $error("enable read returned wrong data");

    // Other reads answer a cycle later too
    AST_READ_SENSE: assert property (bus_req.rd && sel == REG_SENSE |=> rd_data == $past(sense_q))
        else $error("sense read wrong");

    AST_READ_FLAGS: assert property (flag_rd |=> rd_data == ($past(flags_q) & CHAN_MASK)) // see RULE1
        else $error("flag read wrong");

    // Unmapped reads and idle cycles show zero
    AST_READ_NONE: assert property (bus_req.rd && sel == REG_NONE |=> rd_data == RD_UNMAPPED)
        else $error("unmapped read not zero");

    AST_READ_IDLE: assert property (!bus_req.rd |=> rd_data == RD_UNMAPPED)
        else $error("read data out of cycle");

    // Writes land in the addressed byte
    AST_WRITE_SENSE: assert property (bus_req.wr && sel == REG_SENSE |=> sense_q == $past(bus_req.wdata))
        else $error("sense write lost");

    AST_WRITE_ENABLE: assert property (bus_req.wr && sel == REG_ENABLE |=> enable_q == $past(bus_req.wdata))
        else $error("enable write lost");

    // Control bytes change only by own write
    AST_SENSE_HOLDS: assert property (!(bus_req.wr && sel == REG_SENSE) |=> $stable(sense_q))
        else $error("sense byte changed");

    AST_ENABLE_HOLDS: assert property (!(bus_req.wr && sel == REG_ENABLE) |=> $stable(enable_q))
        else $error("enable byte changed");

    // Outputs leave reset at zero
    AST_RESET_OUTPUTS: assert property ($past(srst) |-> rd_data == '0 && irq_req == '0) // see RULE12
        else $error("outputs not zero after reset");

    // Per-channel checks

    for (genvar k = 0; k < NCHAN; k++) begin : g_ast
        if (CHAN_MASK[k]) begin : g_on
            // Read of a set flag, then a write of zero with no new request
            sequence s_armed;
                flag_rd && flags_q[k];
            endsequence
            sequence s_clear_write;
                flag_wr && !bus_req.wdata[k] && sense_q[k] && ext_request_pin_n[k];
            endsequence
            // No flag register access
            sequence s_flag_quiet;
                !flag_wr && !flag_rd;
            endsequence

            // Set conditions per sense mode
            AST_LEVEL_SETS: assert property (!sense_q[k] && !ext_request_pin_n[k] |=> flags_q[k]) // see RULE6
                else $error("low level did not set flag");

            AST_EDGE_SETS: assert property (sense_q[k] && $fell(ext_request_pin_n[k]) |=> flags_q[k]) // see RULE7
                else $error("falling edge did not set flag");

            // Enable gates the request only
            AST_DISABLED_QUIET: assert property (!enable_q[k] |-> !irq_req[k]) // see RULE4
                else $error("disabled channel requested");

            AST_ENABLED_FORWARD: assert property (enable_d[k] && flags_d[k] |=> irq_req[k]) // see RULE5
                else $error("enabled pending channel not forwarded");

            AST_SW_CLEAR: assert property (s_armed ##1 s_clear_write |=> !flags_q[k]) // see RULE8
                else $error("read then write zero did not clear");

            // Same clear with a quiet cycle between
            AST_SW_CLEAR_GAP: assert property (s_armed ##1 s_flag_quiet ##1 s_clear_write
                                               |=> !flags_q[k]) // see RULE8
                else $error("read, pause, zero did not clear");

            // A write disarms: the next zero keeps the flag
            AST_UNARMED_KEEPS: assert property (flag_wr ##1 s_flag_quiet ##1
                                                (flags_q[k] && flag_wr && !bus_req.wdata[k] && !exc_done[k])
                                                |=> flags_q[k]) // see RULE8
                else $error("unarmed zero write cleared");

            // Writes only ever clear
            AST_NO_SW_SET: assert property (!flags_q[k] && flag_wr && sense_q[k] && ext_request_pin_n[k]
                                            |=> !flags_q[k]) // see RULE11
                else $error("software write set a flag");

            AST_WRITE_ONE_KEEPS: assert property (flags_q[k] && flag_wr && bus_req.wdata[k] && !exc_done[k]
                                                  |=> flags_q[k]) // see RULE11
                else $error("write of one cleared a flag");

            // Clearing on handling per mode
            AST_LEVEL_AUTO_CLR: assert property (!sense_q[k] && exc_done[k] && ext_request_pin_n[k]
                                                 |=> !flags_q[k]) // see RULE9
                else $error("level flag not cleared after handling");

            AST_LEVEL_HOLD_LOW: assert property (!sense_q[k] && exc_done[k] && !ext_request_pin_n[k]
                                                 |=> flags_q[k] [*1]) // see RULE9
                else $error("level flag cleared while pin low");

            AST_EDGE_AUTO_CLR: assert property (sense_q[k] && exc_done[k] && ext_request_pin_n[k]
                                                |=> !flags_q[k]) // see RULE10
                else $error("edge flag not cleared after handling");

            // Edge mode clears with the pin held low too
            AST_EDGE_CLR_LOW: assert property (sense_q[k] && exc_done[k] && !$past(srst)
                                               && !$fell(ext_request_pin_n[k]) |=> !flags_q[k]) // see RULE10
                else $error("edge flag kept after handling");

            // No set condition, flag stays clear
            AST_LEVEL_HIGH_QUIET: assert property (!sense_q[k] && !flags_q[k] && ext_request_pin_n[k]
                                                   |=> !flags_q[k]) // see RULE2
                else $error("level flag set, pin high");

            AST_EDGE_NO_FALL_QUIET: assert property (sense_q[k] && !flags_q[k] && !$past(srst)
                                                     && !$fell(ext_request_pin_n[k]) |=> !flags_q[k]) // see RULE3
                else $error("edge flag set with no fall");

            // No clear condition, flag holds
            AST_FLAG_HOLDS: assert property (flags_q[k] && !exc_done[k] && !flag_wr
                                             |=> flags_q[k]) // see RULE8
                else $error("flag dropped with no clear");

            // Request needs flag and enable
            AST_IRQ_NEEDS_BOTH: assert property (irq_req[k] |-> flags_q[k] && enable_q[k]) // see RULE12
                else $error("request without flag and enable");
        end
    end

endmodule : eisf_top

// File: design/eisf_pkg.sv
// ****************************************************************
// External request sense and flag block: shared definitions
// ****************************************************************
package eisf_pkg;

    // ************************************************************
    // Bus and register geometry
    // ************************************************************
    localparam int unsigned ADDR_W = 8;                 // Byte address width
    localparam int unsigned DATA_W = 8;                 // Register width
    localparam int unsigned NCHAN  = 8;                 // Bit positions per register

    // Register byte addresses
    localparam logic [ADDR_W-1:0] OFF_SENSE  = 8'hf4;   // irq_sense_select
    localparam logic [ADDR_W-1:0] OFF_ENABLE = 8'hf5;   // irq_enable_mask
    localparam logic [ADDR_W-1:0] OFF_FLAGS  = 8'hf6;   // irq_pending_flags

    // Channels that exist: 5, 4, 1 and 0
    localparam logic [DATA_W-1:0] CHAN_MASK  = 8'h33;

    // Reset values
    localparam logic [DATA_W-1:0] RST_SENSE  = 8'h00;
    localparam logic [DATA_W-1:0] RST_ENABLE = 8'h00;
    localparam logic [DATA_W-1:0] RST_FLAGS  = 8'h00;
    localparam logic [DATA_W-1:0] RD_UNMAPPED = 8'h00;  // Answer for unmapped reads
    localparam logic              PIN_IDLE   = 1'b1;    // Request pins idle high

    // Sense-select encodings
    localparam logic SENSE_LEVEL = 1'b0;                // Low level requests
    localparam logic SENSE_EDGE  = 1'b1;                // Falling edge requests

    // ************************************************************
    // Types
    // ************************************************************
    // Decoded register target
    typedef enum logic [1:0] {
        REG_NONE   = 2'b00,
        REG_SENSE  = 2'b01,
        REG_ENABLE = 2'b10,
        REG_FLAGS  = 2'b11
    } eisf_reg_e;

    // One register bus request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;                        // Byte address
        logic [DATA_W-1:0] wdata;                       // Write data
        logic              wr;                          // Write strobe
        logic              rd;                          // Read strobe
    } eisf_bus_s;

endpackage : eisf_pkg

// File: design/eisf_chan.sv
`timescale 1ns/100ps
// ****************************************************************
// One request channel: sensing and its pending flag
// ****************************************************************
module eisf_chan (
    input  wire logic sys_clk,
    input  wire logic srst,
    input  wire logic ext_request_pin_n,   // Active-low request pin
    input  wire logic chan_sense_select,   // 0 level, 1 falling edge
    input  wire logic exc_done,            // Exception handling carried out
    input  wire logic flag_rd,             // Flag register read this cycle
    input  wire logic flag_wr,             // Flag register write this cycle
    input  wire logic flag_wbit,           // Written bit value
    output logic      chan_pending_flag,   // Registered flag
    output logic      flag_d               // Next flag value
);
    import eisf_pkg::*;

    logic prev_q,  prev_d;                 // Pin level one cycle ago
    logic arm_q,   arm_d;                  // Flag was read as 1
    logic flag_q;                          // Flag state
    logic set_c;                           // Set condition
    logic auto_clr;                        // Hardware clear
    logic sw_clr;                          // Software clear

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        prev_d = ext_request_pin_n;
        // Set source depends on sense mode
        if (chan_sense_select == SENSE_EDGE) begin
            set_c = prev_q & ~ext_request_pin_n;                    // see RULE3 see RULE7
        end else begin
            set_c = ~ext_request_pin_n;                             // see RULE2 see RULE6
        end
        // Level mode needs the pin high again in the handling cycle
        auto_clr = exc_done & (chan_sense_select | ext_request_pin_n); // see RULE9 see RULE10
        // Write of 0 only counts after a read of 1
        sw_clr = flag_wr & ~flag_wbit & arm_q;                      // see RULE8
        // Set wins over any clear; writing 1 never sets
        flag_d = set_c | (flag_q & ~auto_clr & ~sw_clr);            // see RULE11
        // Arming: any write disarms, a read of 1 arms
        if (flag_wr) begin
            arm_d = 1'b0;
        end else if (flag_rd && flag_q) begin
            arm_d = 1'b1;                                           // see RULE8
        end else begin
            arm_d = arm_q & flag_q;
        end
    end

    // ************************************************************
    // State registers
    // ************************************************************
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            prev_q <= PIN_IDLE;
            arm_q  <= 1'b0;
            flag_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
            arm_q  <= arm_d;
            flag_q <= flag_d;
        end
    end

    assign chan_pending_flag = flag_q;

endmodule : eisf_chan

// File: design/eisf_rdport.sv
`timescale 1ns/100ps
// ****************************************************************
// Read data register: one-cycle read answer
// ****************************************************************
module eisf_rdport (
    input  wire logic                          sys_clk,
    input  wire logic                          srst,
    input  wire logic                          rd,         // Read strobe
    input  wire eisf_pkg::eisf_reg_e           rd_sel,     // Decoded target
    input  wire logic [eisf_pkg::DATA_W-1:0]   sense_q,
    input  wire logic [eisf_pkg::DATA_W-1:0]   enable_q,
    input  wire logic [eisf_pkg::DATA_W-1:0]   flags_q,
    output logic      [eisf_pkg::DATA_W-1:0]   rd_data     // Valid one cycle after rd
);
    import eisf_pkg::*;

    logic [DATA_W-1:0] rdata_q, rdata_d;   // Held answer

    // Select answer; idle cycles return zero
    always_comb begin
        rdata_d = RD_UNMAPPED;
        if (rd) begin
            unique case (rd_sel)
                REG_SENSE:  rdata_d = sense_q;
                REG_ENABLE: rdata_d = enable_q;
                REG_FLAGS:  rdata_d = flags_q & CHAN_MASK;
                REG_NONE:   rdata_d = RD_UNMAPPED;
            endcase
        end
    end

    // Register the answer
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rdata_q <= RD_UNMAPPED;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign rd_data = rdata_q;

endmodule : eisf_rdport

// File: tb/eisf_pin_model.sv
`timescale 1ns/100ps
// ****************************************************************
// External logic driving the active-low request pins
// ****************************************************************
module eisf_pin_model (
    input  wire logic                       sys_clk,
    output logic [eisf_pkg::NCHAN-1:0]      ext_request_pin_n
);
    import eisf_pkg::*;

    // Pins idle high; pulled-up lines never float
    initial begin
        ext_request_pin_n = {NCHAN{PIN_IDLE}};
    end

    // Move one pin just after a clock edge
    task automatic drive(input int ch, input logic lvl);
        @(posedge sys_clk);
        ext_request_pin_n[ch] <= lvl;
    endtask : drive

    // Move all pins at once, unused ones included
    task automatic drive_all(input logic lvl);
        @(posedge sys_clk);
        ext_request_pin_n <= {NCHAN{lvl}};
    endtask : drive_all
endmodule : eisf_pin_model

// File: tb/eisf_top_tb.sv
`timescale 1ns/100ps
// ****************************************************************
// Self-checking bench for the request sense and flag block
// ****************************************************************
module eisf_top_tb;
    import eisf_pkg::*;

    logic              sys_clk;      // 20 MHz clock
    logic              srst;         // Synchronous reset
    eisf_bus_s         bus_req;      // Register bus request
    logic [DATA_W-1:0] rd_data;      // Read answer
    logic [NCHAN-1:0]  pin_n;        // Request pins from the model
    logic [NCHAN-1:0]  exc_done;     // Exception handling pulses
    logic [NCHAN-1:0]  irq_req;      // Requests to the processor
    int                err_count;    // Mismatches
    int                checked;      // Comparisons made
    logic [DATA_W-1:0] rv;           // Last read value
    int                chans[4] = '{0, 1, 4, 5};

    eisf_top i_dut (.sys_clk(sys_clk), .srst(srst), .bus_req(bus_req), .rd_data(rd_data),
                    .ext_request_pin_n(pin_n), .exc_done(exc_done), .irq_req(irq_req));
    eisf_pin_model i_pins (.sys_clk(sys_clk), .ext_request_pin_n(pin_n));

    // ************************************************************
    // Shared tasks
    // ************************************************************
    // Compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus_req <= '0;
    endtask : wr

    // One-cycle read strobe; answer sampled in the following cycle only
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus_req <= '0;
        #1 rv = rd_data;
    endtask : rd

    // Let the next edge land, then look
    task automatic settle();
        @(posedge sys_clk);
        #1;
    endtask : settle

    // Exception handling done for one channel
    task automatic pulse(input int ch);
        @(posedge sys_clk);
        exc_done <= 8'h01 << ch;
        @(posedge sys_clk);
        exc_done <= '0;
        #1;
    endtask : pulse

    // Single place that ends the run
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out

    // ************************************************************
    // Scenarios
    // ************************************************************
    // Reset values, storage, unmapped address
    task automatic t_regs();
        rd(OFF_SENSE);   check(rv, 8'h00, "sense reset");
        rd(OFF_ENABLE);  check(rv, 8'h00, "enable reset");
        rd(OFF_FLAGS);   check(rv, 8'h00, "flags reset");
        check(irq_req, 8'h00, "irq after reset");
        wr(OFF_SENSE, 8'ha5);  rd(OFF_SENSE);  check(rv, 8'ha5, "sense rw");
        wr(OFF_ENABLE, 8'hc3); rd(OFF_ENABLE); check(rv, 8'hc3, "enable rw");
        rd(8'hf7);       check(rv, 8'h00, "unmapped read");
        wr(OFF_SENSE, 8'h00);
        wr(OFF_ENABLE, 8'h00);
        $display("test regs done");
    endtask : t_regs

    // Only four channels flag; clear by read then write zero
    task automatic t_map();
        wr(OFF_ENABLE, 8'hff);
        i_pins.drive_all(1'b0);
        settle();
        i_pins.drive_all(1'b1);
        rd(OFF_FLAGS);   check(rv, CHAN_MASK, "only 5,4,1,0 flag");
        check(irq_req, CHAN_MASK, "irq only on real channels");
        wr(OFF_FLAGS, 8'h00);
        rd(OFF_FLAGS);   check(rv, 8'h00, "armed clear");
        $display("test map done");
    endtask : t_map

    // Level sensing: set while low, cleared only once high and handled
    task automatic t_level();
        wr(OFF_ENABLE, CHAN_MASK);
        foreach (chans[i]) begin
            i_pins.drive(chans[i], 1'b0);
            settle();
            check(irq_req, 8'h01 << chans[i], "level set");
            pulse(chans[i]);
            check(irq_req, 8'h01 << chans[i], "handled while low");
            i_pins.drive(chans[i], 1'b1);
            settle();
            check(irq_req, 8'h01 << chans[i], "high not handled");
            pulse(chans[i]);
            check(irq_req, 8'h00, "handled while high");
        end
        $display("test level done");
    endtask : t_level

    // Edge sensing: set on fall only, cleared when handled
    task automatic t_edge();
        wr(OFF_SENSE, CHAN_MASK);
        foreach (chans[i]) begin
            i_pins.drive(chans[i], 1'b0);
            settle();
            check(irq_req, 8'h01 << chans[i], "edge set");
            pulse(chans[i]);
            check(irq_req, 8'h00, "edge handled");
            repeat (3) @(posedge sys_clk);
            #1 check(irq_req, 8'h00, "held low is no new edge");
            i_pins.drive(chans[i], 1'b1);
        end
        $display("test edge done");
    endtask : t_edge

    // Software clearing: unarmed zero, ones, armed zero
    task automatic t_swclr();
        i_pins.drive(5, 1'b0);
        i_pins.drive(5, 1'b1);
        wr(OFF_FLAGS, 8'hff);
        wr(OFF_FLAGS, 8'h00);
        rd(OFF_FLAGS);   check(rv, 8'h20, "zero without read");
        wr(OFF_FLAGS, 8'hff);
        rd(OFF_FLAGS);   check(rv, 8'h20, "ones leave flag");
        wr(OFF_FLAGS, 8'h00);
        rd(OFF_FLAGS);   check(rv, 8'h00, "read then zero");
        wr(OFF_FLAGS, 8'hff);
        rd(OFF_FLAGS);   check(rv, 8'h00, "ones never set");
        $display("test swclr done");
    endtask : t_swclr

    // Enable gates forwarding but not the flag
    task automatic t_enable();
        wr(OFF_ENABLE, 8'h00);
        i_pins.drive(1, 1'b0);
        settle();
        check(irq_req, 8'h00, "disabled blocks");
        rd(OFF_FLAGS);   check(rv, 8'h02, "flag still set");
        wr(OFF_ENABLE, 8'h02);
        #1 check(irq_req, 8'h02, "enable forwards");
        wr(OFF_ENABLE, 8'h00);
        #1 check(irq_req, 8'h00, "disable again");
        pulse(1);
        i_pins.drive(1, 1'b1);
        $display("test enable done");
    endtask : t_enable

    // ************************************************************
    // Clock, watchdog, main sequence
    // ************************************************************
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // Cuts a hang short; far above the whole sequence
    initial begin
        repeat (5000) @(posedge sys_clk);
        err_count++;
        close_out();
    end

    initial begin
        srst = 1'b1;
        bus_req = '0;
        exc_done = '0;
        err_count = 0;
        checked = 0;
        repeat (20) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        t_regs();
        t_map();
        t_level();
        t_edge();
        t_swclr();
        t_enable();
        close_out();
    end
endmodule : eisf_top_tb
